//--- hdl/standby_ctrl.v
// standby controller: halt, idle and stop modes with wake-up, plus reset collection
// assumes it runs on an always-on clock; gating outputs drive the clock tree
// Summary of operation
// - halt gates only the CPU clock
// - halt exits on NMI, unmasked interrupt, reset
// - idle stops all but oscillator, PLL, clock monitor and listed blocks
// - idle/stop exit on pin, slave serial, resets
// - stop halts everything including the oscillator, except selected slave channels
// - idle keeps oscillator running, output blocked
// - only first three slave channels run asleep
// - keep RAM, registers; hold ports, freeze state
// - droop interrupt on configured falling/rising crossing
// - droop reset while supply below level
// - two software-selectable thresholds, one control bit
// - droop detector works in stop mode
// - detection sets a readable flag
// - reset mode locked until non-droop reset
// - power-up clear resets in every mode
`timescale 1ns/1ps
`include "standby_map.vh"

module standby_ctrl #(
   parameter EXT_PINS            = 4,
   parameter DROOP_SETTLE_CYCLES = `SBY_DROOP_SETTLE_NS / `SBY_CLK_PERIOD_NS
) (
   input  wire                           clk,
   input  wire                           arst_n,
   input  wire [1:0]                     modeRequest,
   input  wire                           modeRequestStrobe,
   input  wire                           watchdogNmiRequest,
   input  wire                           maskedIrqPending,
   input  wire                           watchdogOverflow,
   input  wire [EXT_PINS-1:0]            externalInterruptPin,
   input  wire [EXT_PINS-1:0]            externalInterruptMask,
   input  wire [`SBY_SLAVE_CHANNELS-1:0] serialChannelIrq,
   input  wire [`SBY_SLAVE_CHANNELS-1:0] serialClockInputSel,
   input  wire                           resetPin_n,
   input  wire                           powerUpClearBelow,
   input  wire                           droopBelow,
   input  wire                           droopEnable,
   input  wire                           droopResetMode,
   input  wire [1:0]                     droopEdgeSelect,
   input  wire                           droopLevelSelect,
   input  wire                           droopFlagClear,
   output reg  [1:0]                     modeState,
   output reg                            cpuClockEnable,
   output reg                            periphClockEnable,
   output reg                            oscEnable,
   output reg                            oscOutputEnable,
   output reg                            pllEnable,
   output reg                            clockMonitorEnable,
   output reg  [`SBY_SLAVE_CHANNELS-1:0] serialChannelEnable,
   output reg                            portHold,
   output reg                            stateFreeze,
   output reg                            wakeInterrupt,
   output reg                            systemReset,
   output wire                           droopLevelCtrl,
   output wire                           droopIrq,
   output wire                           droopFlag,
   output wire                           droopLocked,
   output wire                           droopReady
);

   // =====================================================================
   // input synchronisers: pins and analog comparators are asynchronous
   localparam SYNC_W = EXT_PINS + 3;

   wire [SYNC_W-1:0] asyncIn = {droopBelow, powerUpClearBelow, resetPin_n, externalInterruptPin};
   reg  [SYNC_W-1:0] syncStage1_reg;
   reg  [SYNC_W-1:0] syncStage2_reg;

   genvar g;
   generate
      for (g = 0; g < SYNC_W; g = g + 1) begin : gen_sync
         always @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               syncStage1_reg[g] <= 1'b0;
               syncStage2_reg[g] <= 1'b0;
            end else begin
               syncStage1_reg[g] <= asyncIn[g];
               syncStage2_reg[g] <= syncStage1_reg[g];
            end
         end
      end
   endgenerate

   wire [EXT_PINS-1:0] extPinSync    = syncStage2_reg[EXT_PINS-1:0];
   // reset pin reads as asserted until two clean samples have arrived
   wire                pinReset      = ~syncStage2_reg[EXT_PINS];
   wire                pocBelowSync  = syncStage2_reg[EXT_PINS+1];
   wire                droopBelowSync = syncStage2_reg[EXT_PINS+2];

   // =====================================================================
   // droop detector
   wire droopResetReq;
   wire wdtReset;
   wire otherReset;

   droop_monitor #(
      .SETTLE_CYCLES (DROOP_SETTLE_CYCLES)
   ) u_droop (
      .clk         (clk),
      .arst_n      (arst_n),
      .belowLevel  (droopBelowSync),
      .enableIn    (droopEnable),
      .resetModeIn (droopResetMode),
      .edgeSelect  (droopEdgeSelect),
      .levelSelect (droopLevelSelect),
      .flagClear   (droopFlagClear),
      .otherReset  (otherReset),
      .levelCtrl   (droopLevelCtrl),
      .droopIrq    (droopIrq),
      .droopReset  (droopResetReq),
      .droopFlag   (droopFlag),
      .droopLocked (droopLocked),
      .droopReady  (droopReady)
   );

   // =====================================================================
   // reset collection
   // watchdog is stopped in idle and stop, so its overflow only counts awake
   assign wdtReset   = watchdogOverflow &
                       ((modeState == `SBY_MODE_RUN) | (modeState == `SBY_MODE_HALT));
   assign otherReset = pinReset | wdtReset | pocBelowSync;
   wire   anyReset   = otherReset | droopResetReq;

   localparam integer                HOLD_LOAD_INT = `SBY_RESET_HOLD_CYCLES;
   localparam [`SBY_RESET_CNT_W-1:0] HOLD_LOAD     = HOLD_LOAD_INT[`SBY_RESET_CNT_W-1:0];

   reg [`SBY_RESET_CNT_W-1:0] holdCnt_reg;

   // stretched so every consumer sees at least the hold length of reset
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         holdCnt_reg <= HOLD_LOAD;
         systemReset <= 1'b1;
      end else begin
         if (anyReset) begin
            holdCnt_reg <= HOLD_LOAD;
         end else if (holdCnt_reg != {`SBY_RESET_CNT_W{1'b0}}) begin
            holdCnt_reg <= holdCnt_reg - 1'b1;
         end
         systemReset <= anyReset | (holdCnt_reg != {`SBY_RESET_CNT_W{1'b0}});
      end
   end

   // =====================================================================
   // wake-up sources
   wire haltWake  = watchdogNmiRequest | maskedIrqPending;
   wire deepWake  = (|(extPinSync & ~externalInterruptMask)) |
                    (|(serialChannelIrq & serialClockInputSel));

   // =====================================================================
   // mode state machine
   reg [1:0] modeState_next;
   reg       wake_next;

   always @* begin
      modeState_next = modeState;
      wake_next      = 1'b0;
      case (modeState)
         `SBY_MODE_RUN: begin
            if (modeRequestStrobe && !systemReset) begin
               modeState_next = modeRequest;
            end
         end
         `SBY_MODE_HALT: begin
            if (haltWake) begin
               modeState_next = `SBY_MODE_RUN;
               wake_next      = 1'b1;
            end
         end
         `SBY_MODE_IDLE, `SBY_MODE_STOP: begin
            if (deepWake) begin
               modeState_next = `SBY_MODE_RUN;
               wake_next      = 1'b1;
            end
         end
         default: begin
            modeState_next = `SBY_MODE_RUN;
         end
      endcase
      // a reset wake takes the normal reset path instead of resuming
      if (anyReset) begin
         modeState_next = `SBY_MODE_RUN;
         wake_next      = 1'b0;
      end
   end

   // =====================================================================
   // gating outputs, all registered from the next state
   reg                           cpuClk_next;
   reg                           periphClk_next;
   reg                           osc_next;
   reg                           oscOut_next;
   reg                           pll_next;
   reg                           clkMon_next;
   reg [`SBY_SLAVE_CHANNELS-1:0] serial_next;
   reg                           hold_next;

   always @* begin
      cpuClk_next    = 1'b1;
      periphClk_next = 1'b1;
      osc_next       = 1'b1;
      oscOut_next    = 1'b1;
      pll_next       = 1'b1;
      clkMon_next    = 1'b1;
      serial_next    = {`SBY_SLAVE_CHANNELS{1'b1}};
      hold_next      = 1'b0;
      case (modeState_next)
         `SBY_MODE_RUN: begin
         end
         `SBY_MODE_HALT: begin
            cpuClk_next = 1'b0;
         end
         `SBY_MODE_IDLE: begin
            cpuClk_next    = 1'b0;
            periphClk_next = 1'b0;
            oscOut_next    = 1'b0;
            serial_next    = serialClockInputSel;
            hold_next      = 1'b1;
         end
         `SBY_MODE_STOP: begin
            cpuClk_next    = 1'b0;
            periphClk_next = 1'b0;
            osc_next       = 1'b0;
            oscOut_next    = 1'b0;
            pll_next       = 1'b0;
            clkMon_next    = 1'b0;
            serial_next    = serialClockInputSel;
            hold_next      = 1'b1;
         end
         default: begin
         end
      endcase
   end

   // RAM and registers keep contents: nothing here clears them
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         modeState           <= `SBY_MODE_RUN;
         cpuClockEnable      <= 1'b1;
         periphClockEnable   <= 1'b1;
         oscEnable           <= 1'b1;
         oscOutputEnable     <= 1'b1;
         pllEnable           <= 1'b1;
         clockMonitorEnable  <= 1'b1;
         serialChannelEnable <= {`SBY_SLAVE_CHANNELS{1'b1}};
         portHold            <= 1'b0;
         stateFreeze         <= 1'b0;
         wakeInterrupt       <= 1'b0;
      end else begin
         modeState           <= modeState_next;
         cpuClockEnable      <= cpuClk_next;
         periphClockEnable   <= periphClk_next;
         oscEnable           <= osc_next;
         oscOutputEnable     <= oscOut_next;
         pllEnable           <= pll_next;
         clockMonitorEnable  <= clkMon_next;
         serialChannelEnable <= serial_next;
         portHold            <= hold_next;
         stateFreeze         <= hold_next;
         wakeInterrupt       <= wake_next;
      end
   end

endmodule // standby_ctrl

//--- hdl/standby_map.vh
// constants for the standby controller and the supply droop detector
// assumes a single always-on 200 MHz clock feeds the controller itself
`ifndef STANDBY_MAP_VH
`define STANDBY_MAP_VH

// =====================================================================
// standby modes (request code and state code)
`define SBY_MODE_RUN          2'h0
`define SBY_MODE_HALT         2'h1
`define SBY_MODE_IDLE         2'h2
`define SBY_MODE_STOP         2'h3

// =====================================================================
// serial channels able to run as slaves in idle and stop
`define SBY_SLAVE_CHANNELS    3

// =====================================================================
// droop detector configuration
`define SBY_EDGE_FALL_BIT     0
`define SBY_EDGE_RISE_BIT     1
`define SBY_LEVEL_4V4         1'h0
`define SBY_LEVEL_4V2         1'h1
`define SBY_LEVEL_RESET       1'h0
`define SBY_POC_LEVEL_MV      3700

// =====================================================================
// timing
`define SBY_CLK_PERIOD_NS     5
`define SBY_DROOP_SETTLE_NS   100000
`define SBY_SETTLE_CNT_W      15
`define SBY_RESET_HOLD_CYCLES 16
`define SBY_RESET_CNT_W       5

`endif

//--- hdl/droop_monitor.v
// supply droop detector control: threshold select, flag, interrupt, reset, lock
// assumes the comparator output arrives already synchronised to clk
`timescale 1ns/1ps
`include "standby_map.vh"

module droop_monitor #(
   parameter SETTLE_CYCLES = `SBY_DROOP_SETTLE_NS / `SBY_CLK_PERIOD_NS
) (
   input  wire       clk,
   input  wire       arst_n,
   input  wire       belowLevel,
   input  wire       enableIn,
   input  wire       resetModeIn,
   input  wire [1:0] edgeSelect,
   input  wire       levelSelect,
   input  wire       flagClear,
   input  wire       otherReset,
   output wire       levelCtrl,
   output reg        droopIrq,
   output reg        droopReset,
   output reg        droopFlag,
   output reg        droopLocked,
   output reg        droopReady
);

   // =====================================================================
   // lock and effective configuration
   // settle count must fit the counter width; larger values wrap
   localparam integer                 SETTLE_LAST_INT = SETTLE_CYCLES - 1;
   localparam [`SBY_SETTLE_CNT_W-1:0] SETTLE_LAST     = SETTLE_LAST_INT[`SBY_SETTLE_CNT_W-1:0];

   reg                          levelSel_reg;
   reg                          below_reg;
   reg  [`SBY_SETTLE_CNT_W-1:0] settle_reg;
   wire                         enabled   = enableIn | droopLocked;
   wire                         resetMode = resetModeIn | droopLocked;
   wire                         fallEvent = droopReady & belowLevel & ~below_reg;
   wire                         riseEvent = droopReady & ~belowLevel & below_reg;

   // frozen while locked so the comparator setting cannot be moved away
   assign levelCtrl = levelSel_reg;

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         levelSel_reg <= `SBY_LEVEL_RESET;
         below_reg    <= 1'b0;
         settle_reg   <= {`SBY_SETTLE_CNT_W{1'b0}};
         droopReady   <= 1'b0;
         droopLocked  <= 1'b0;
         droopIrq     <= 1'b0;
         droopReset   <= 1'b0;
         droopFlag    <= 1'b0;
      end else begin
         below_reg <= belowLevel;
         if (!droopLocked) begin
            levelSel_reg <= levelSelect;
         end
         // comparator output is untrusted until the settle time has passed
         if (!enabled) begin
            settle_reg <= {`SBY_SETTLE_CNT_W{1'b0}};
            droopReady <= 1'b0;
         end else if (settle_reg == SETTLE_LAST) begin
            droopReady <= 1'b1;
         end else begin
            settle_reg <= settle_reg + 1'b1;
         end
         if (otherReset) begin
            droopLocked <= 1'b0;
         end else if (enableIn && resetModeIn) begin
            droopLocked <= 1'b1;
         end
         // no mode input: keeps running in every standby mode
         droopIrq   <= enabled & ~resetMode &
                       ((fallEvent & edgeSelect[`SBY_EDGE_FALL_BIT]) |
                        (riseEvent & edgeSelect[`SBY_EDGE_RISE_BIT]));
         droopReset <= enabled & resetMode & droopReady & belowLevel;
         // set wins over clear
         if (enabled && fallEvent) begin
            droopFlag <= 1'b1;
         end else if (flagClear) begin
            droopFlag <= 1'b0;
         end
      end
   end

endmodule // droop_monitor

//--- testbench/standby_ctrl_assertions.sv
// checker on the standby controller top ports
// assumes it is bound into standby_ctrl; arst_n resets it
`timescale 1ns/1ps
module standby_ctrl_checker (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic [1:0] modeState,
   input wire logic       cpuClockEnable,
   input wire logic       periphClockEnable,
   input wire logic       oscEnable,
   input wire logic       oscOutputEnable,
   input wire logic       pllEnable,
   input wire logic       clockMonitorEnable,
   input wire logic [2:0] serialChannelEnable,
   input wire logic [2:0] serialClockInputSel,
   input wire logic [2:0] serialChannelIrq,
   input wire logic       portHold,
   input wire logic       stateFreeze,
   input wire logic       wakeInterrupt,
   input wire logic       systemReset,
   input wire logic       watchdogNmiRequest,
   input wire logic       maskedIrqPending,
   input wire logic       watchdogOverflow,
   input wire logic       resetPin_n,
   input wire logic       powerUpClearBelow,
   input wire logic       droopBelow,
   input wire logic       droopLocked,
   input wire logic       droopLevelCtrl,
   input wire logic       droopIrq
);
   // ==========================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire logic quiet;
   assign quiet = resetPin_n && !watchdogOverflow && !powerUpClearBelow && !systemReset;

   halt_gate_a:
   assert property (modeState == 2'h1 |-> !cpuClockEnable && periphClockEnable && oscOutputEnable && pllEnable)
      else $error("halt gating wrong");
   idle_gate_a:
   assert property (modeState == 2'h2 |-> oscEnable && !oscOutputEnable && !periphClockEnable && portHold
      && stateFreeze && serialChannelEnable == serialClockInputSel) else $error("idle gating wrong");
   stop_gate_a:
   assert property (modeState == 2'h3 |-> !oscEnable && !pllEnable && !clockMonitorEnable && portHold)
      else $error("stop gating wrong");
   halt_wake_a:
   assert property (modeState == 2'h1 && (watchdogNmiRequest || maskedIrqPending) && quiet
      |=> modeState == 2'h0 && wakeInterrupt) else $error("halt wake missed");
   sleep_wake_a:
   assert property (modeState[1] && |(serialChannelIrq & serialClockInputSel) && quiet
      |=> modeState == 2'h0 && wakeInterrupt) else $error("serial wake missed");
   wdog_reset_a:
   assert property (watchdogOverflow && !modeState[1] |=> systemReset && modeState == 2'h0)
      else $error("watchdog reset missed");
   reset_hold_a:
   assert property ($rose(systemReset) |=> systemReset [*8]) else $error("reset too short");
   droop_reset_a:
   assert property ((droopLocked && droopBelow) [*6] |-> systemReset) else $error("droop reset missed");
   clear_reset_a:
   assert property (powerUpClearBelow [*4] |-> systemReset) else $error("power-up clear missed");
   lock_hold_a:
   assert property (droopLocked && resetPin_n && !watchdogOverflow && !powerUpClearBelow |=> droopLocked)
      else $error("lock dropped");
   level_frozen_a:
   assert property (droopLocked && $past(droopLocked) |-> $stable(droopLevelCtrl)) else $error("level moved");
   irq_pulse_a:
   assert property (droopIrq |=> !droopIrq) else $error("irq not a pulse");

   cover property (modeState == 2'h1 ##1 wakeInterrupt);
   cover property (modeState == 2'h3 ##1 wakeInterrupt);
   cover property (droopIrq);
endmodule // standby_ctrl_checker

bind standby_ctrl standby_ctrl_checker standby_ctrl_checker_i (.*);

//--- testbench/cpu_side_model.sv
// far side: software issuing mode requests and pacing droop flag reads
// assumes go and code change on the falling edge; ready low in reset
`timescale 1ns/1ps
module cpu_side_model #(
   parameter SETTLE = 20000
) (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [1:0] code,
   input  wire logic       ready,
   input  wire logic       droopOn,
   output logic [1:0]      modeRequest,
   output logic            modeRequestStrobe,
   output logic            readOk
);
   // ==========================================
   // request issue and settle pacing
   int waitCnt = 0;
   initial begin
      modeRequest = 2'h0;
      modeRequestStrobe = 1'b0;
      readOk = 1'b0;
   end
   always @(negedge clk) begin
      modeRequestStrobe <= go && ready;
      // idle code toggles so a stale value never looks valid
      modeRequest <= go ? code : ~modeRequest;
      waitCnt <= droopOn ? waitCnt + 1 : 0;
      readOk <= droopOn && waitCnt >= SETTLE;
   end
endmodule // cpu_side_model

//--- testbench/tb_standby_ctrl.sv
// testbench for standby_ctrl: modes, wake, resets, droop detector
// assumes 200 MHz clk; inputs change on the falling edge
`timescale 1ns/1ps
module tb_standby_ctrl;
   // ==========================================
   // stimulus, design and far side
   logic clk = 0, arst_n = 0, go = 0, nmiReq = 0, irqPend = 0, wdOvf = 0, clrLow = 0;
   logic dBelow = 0, dEn = 0, dRstMode = 0, dLvl = 0, dClr = 0, rstPin_n = 1;
   logic [1:0] code = 2'h0, dEdge = 2'h1, modeReq, modeState;
   logic [3:0] extPin = 4'h0, extMask = 4'h1;
   logic [2:0] serIrq = 3'h0, serSel = 3'h0, serEn;
   logic strobe, cpuEn, perEn, oscEn, oscOut, pllEn, cmEn, hold, frz, wake, sysRst;
   logic lvlCtrl, dIrq, dFlag, dLock, dRdy, readOk;
   int mismatches = 0, n_tests = 0;

   always #2.5 clk = ~clk;

   standby_ctrl #(.DROOP_SETTLE_CYCLES(8)) standby_ctrl_i (
      .clk(clk), .arst_n(arst_n), .modeRequest(modeReq), .modeRequestStrobe(strobe),
      .watchdogNmiRequest(nmiReq), .maskedIrqPending(irqPend), .watchdogOverflow(wdOvf),
      .externalInterruptPin(extPin), .externalInterruptMask(extMask), .serialChannelIrq(serIrq),
      .serialClockInputSel(serSel), .resetPin_n(rstPin_n), .powerUpClearBelow(clrLow),
      .droopBelow(dBelow), .droopEnable(dEn), .droopResetMode(dRstMode), .droopEdgeSelect(dEdge),
      .droopLevelSelect(dLvl), .droopFlagClear(dClr), .modeState(modeState), .cpuClockEnable(cpuEn),
      .periphClockEnable(perEn), .oscEnable(oscEn), .oscOutputEnable(oscOut), .pllEnable(pllEn),
      .clockMonitorEnable(cmEn), .serialChannelEnable(serEn), .portHold(hold), .stateFreeze(frz),
      .wakeInterrupt(wake), .systemReset(sysRst), .droopLevelCtrl(lvlCtrl), .droopIrq(dIrq),
      .droopFlag(dFlag), .droopLocked(dLock), .droopReady(dRdy));
   cpu_side_model #(.SETTLE(8)) cpu_side_model_i (
      .clk(clk), .go(go), .code(code), .ready(!sysRst), .droopOn(dEn),
      .modeRequest(modeReq), .modeRequestStrobe(strobe), .readOk(readOk));

   // ==========================================
   // helpers
   task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return sysRst;
         1: return dIrq;
         2: return dRdy;
         3: return wake;
         4: return dLock;
         default: return readOk;
      endcase
   endfunction
   task automatic waitFor(input int k, input logic v);
      int n;
      n = 0;
      while (sig(k) !== v) begin
         if (n++ == 200) begin
            mismatches++;
            $display("MISMATCH wait%0d expected %h seen timeout", k, v);
            finish_test;
         end
         @(negedge clk);
      end
   endtask
   task req(input logic [1:0] c);
      @(negedge clk);
      code <= c;
      go <= 1;
      @(negedge clk);
      go <= 0;
      @(negedge clk);
   endtask

   // ==========================================
   // scenarios
   task t_halt;
      for (int i = 0; i < 2; i++) begin
         req(2'h1);
         chk("cpuEn", 0, cpuEn);
         chk("perEn", 1, perEn && oscOut);
         req(2'h2);
         chk("refused", 1, modeState);
         if (i == 0) irqPend <= 1;
         else nmiReq <= 1;
         waitFor(3, 1);
         chk("mode", 0, modeState);
         @(negedge clk);
         irqPend <= 0;
         nmiReq <= 0;
      end
      $display("halt test done");
   endtask
   task t_idle;
      serSel <= 3'h5;
      req(2'h2);
      chk("osc", 2, {oscEn, oscOut});
      chk("perPll", 1, {perEn, pllEn});
      chk("serEn", 4'h5, serEn);
      chk("hold", 1, hold && frz);
      nmiReq <= 1;
      wdOvf <= 1;
      serIrq <= 3'h2;
      extPin <= 4'h1;
      repeat (4) @(negedge clk);
      chk("stay", 2, modeState);
      chk("noRst", 0, sysRst);
      nmiReq <= 0;
      wdOvf <= 0;
      serIrq <= 3'h0;
      extPin <= 4'h5;
      waitFor(3, 1);
      chk("mode", 0, modeState);
      extPin <= 4'h0;
      $display("idle test done");
   endtask
   task t_stop;
      req(2'h3);
      chk("oscPll", 0, {oscEn, pllEn, cmEn});
      chk("hold", 1, hold);
      serIrq <= 3'h1;
      waitFor(3, 1);
      chk("mode", 0, modeState);
      serIrq <= 3'h0;
      $display("stop test done");
   endtask
   task automatic t_wdog;
      int n;
      wdOvf <= 1;
      @(negedge clk);
      wdOvf <= 0;
      chk("rst", 1, sysRst);
      n = 0;
      while (sysRst === 1'b1) begin
         if (n == 100) begin
            mismatches++;
            $display("MISMATCH stretch expected 0 seen timeout");
            finish_test;
         end
         @(negedge clk);
         n++;
      end
      // one cycle of the source plus the 16-cycle stretch
      chk("stretch", 1, n == 17);
      $display("watchdog test done");
   endtask
   task t_droop;
      dLvl <= 1;
      dEn <= 1;
      waitFor(2, 1);
      waitFor(5, 1);
      chk("lvl", 1, lvlCtrl);
      dBelow <= 1;
      waitFor(1, 1);
      chk("flag", 1, dFlag);
      dClr <= 1;
      @(negedge clk);
      dClr <= 0;
      @(negedge clk);
      chk("clr", 0, dFlag);
      dEdge <= 2'h2;
      dBelow <= 0;
      waitFor(1, 1);
      chk("noRst", 0, sysRst);
      $display("droop test done");
   endtask
   task t_lock;
      dRstMode <= 1;
      dLvl <= 0;
      waitFor(4, 1);
      req(2'h3);
      dEn <= 0;
      dLvl <= 1;
      dBelow <= 1;
      waitFor(0, 1);
      chk("mode", 0, modeState);
      chk("frozen", 0, lvlCtrl);
      repeat (4) @(negedge clk);
      dBelow <= 0;
      waitFor(0, 0);
      chk("lock", 1, dLock);
      clrLow <= 1;
      repeat (4) @(negedge clk);
      clrLow <= 0;
      chk("pucRst", 1, sysRst);
      waitFor(0, 0);
      chk("unlock", 0, dLock);
      $display("lock test done");
   endtask

   initial begin
      repeat (2) @(negedge clk);
      arst_n <= 1;
      waitFor(0, 0);
      t_halt;
      t_idle;
      t_stop;
      t_wdog;
      t_droop;
      t_lock;
      finish_test;
   end
endmodule // tb_standby_ctrl
